// [include/dpedac_pkg.sv]
// How it works
// - Row strobe four clocks, precharge three clocks
// - First acknowledge at first edge after strobe
// - No extra waits during burst accesses
// - Low wait-extend input adds one acknowledge clock
// - Acknowledge handshake output, non-interleaved mode
// - Refresh divider by ten gives 2 MHz
// - Upper bank select drives two row strobes
// - Zero column setup, 15 ns row hold
// - Write column strobe two clocks after row
// - Port A request from select strobe, clock high
// - Port B request from select and strobe
// - Count enable from acked requests or refresh
// - Delay chain starts on acked request, advances
// - Scrub single error extends refresh until done
// - Read transceiver enable until termination given
// - Correction output enable on reads, scrub errors
// - Scrub refresh six clocks, eight with error
// - Both ports ended by synchronous termination
`default_nettype none
package dpedac_pkg;
   // ==========================================================
   // Strap values and timing
   // ==========================================================
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned CLK_PERIOD_NS   = 50;
   localparam int unsigned ROW_LOW_CLKS    = 4;
   localparam int unsigned ROW_PRECH_CLKS  = 3;
   localparam int unsigned ACK_BASE_CLKS   = 1;
   localparam int unsigned WAIT_EXTRA_CLKS = 1;
   localparam int unsigned BURST_WAIT_CLKS = 0;
   localparam int unsigned REFRESH_HZ      = 2_000_000;
   localparam int unsigned REF_DIV         = CLK_HZ / REFRESH_HZ;
   localparam logic [2:0]  REF_DIV_CODE    = 3'h0;
   localparam int unsigned COL_SETUP_NS    = 0;
   localparam int unsigned ROW_HOLD_NS     = 15;
   // Hold rounds up to whole cycles, at least one
   localparam int unsigned ROW_HOLD_CLKS   =
      ((ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
      ((ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int unsigned WR_CAS_DELAY    = 1;
   localparam int unsigned SCRUB_CLKS      = 6;
   localparam int unsigned SCRUB_ERR_CLKS  = 8;
   localparam int unsigned CHAIN_LEN       = 6;

   // Strobe outputs to the memory array
   typedef struct packed {
      logic [3:0] row_n;
      logic [3:0] col_n;
      logic       row_addr_sel;
   } dpedac_mem_t;

   // Glue enables toward transceivers and correction unit
   typedef struct packed {
      logic tran_en;
      logic correction_data_output_enable;
      logic extend_refresh;
   } dpedac_glue_t;
endpackage
`default_nettype wire

// [verilog/dpedac_refdiv.sv]
`default_nettype none
// ============================================================
// Refresh divider clock enable
// ============================================================
module dpedac_refdiv #(
   parameter int unsigned DIV = 10
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Divided enable
   output logic      tick_o
);
   logic [7:0] cnt_r, cnt_nxt;
   logic       tick_nxt;

   // One-cycle pulse every DIV clocks, 20 MHz down to 2 MHz
   always_comb begin
      tick_nxt = 1'b0;
      cnt_nxt  = cnt_r + 8'h01;
      if (cnt_r == 8'(DIV - 1)) begin
         cnt_nxt  = 8'h00;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r  <= 8'h00;
         tick_o <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_o <= tick_nxt;
      end
   end
endmodule
`default_nettype wire

// [verilog/dpedac_ctrl.sv]
`default_nettype none
// ============================================================
// Dual-port corrected memory controller and glue sequencer
// ============================================================
module dpedac_ctrl
   import dpedac_pkg::*;
#(
   parameter int unsigned REFRESH_TICKS = 8
) (
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // Port A processor
   input  wire logic                     port_a_select_strobe_n_i,
   input  wire logic                     port_a_write_i,
   input  wire logic                     port_a_burst_i,
   // Port B processor
   input  wire logic                     port_b_chip_select_n_i,
   input  wire logic                     port_b_address_strobe_n_i,
   input  wire logic                     port_b_write_i,
   input  wire logic                     port_b_burst_i,
   // Strap and correction unit inputs
   input  wire logic                     wait_extend_in_n_i,
   input  wire logic                     bank_select_i,
   input  wire logic                     single_error_flag_i,
   // Port terminations and grant
   output logic                          port_a_sync_termination_o,
   output logic                          port_b_sync_termination_o,
   output logic                          port_b_granted_o,
   output logic                          access_ack_o,
   output logic                          refresh_in_progress_o,
   // Memory and glue
   output dpedac_pkg::dpedac_mem_t       mem_o,
   output dpedac_pkg::dpedac_glue_t      glue_o
);
   import dpedac_pkg::*;

   // ==========================================================
   // Divider and refresh request
   // ==========================================================
   typedef enum logic [2:0] {
      DP_IDLE, DP_ROW, DP_SCRUB, DP_DONE, DP_PRECH
   } dpedac_state_t;

   dpedac_state_t state_r, state_nxt;
   logic       ref_tick;
   logic [7:0] ref_cnt_r, ref_cnt_nxt;
   logic       ref_pend_r, ref_pend_nxt;

   dpedac_refdiv #(.DIV(REF_DIV)) u_div (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_o (ref_tick)
   );

   // Refresh becomes due after a number of divided ticks
   always_comb begin
      ref_cnt_nxt  = ref_cnt_r;
      ref_pend_nxt = ref_pend_r;
      if (ref_tick) begin
         if (ref_cnt_r == 8'(REFRESH_TICKS - 1)) begin
            ref_cnt_nxt  = 8'h00;
            ref_pend_nxt = 1'b1;
         end else begin
            ref_cnt_nxt = ref_cnt_r + 8'h01;
         end
      end
      // A pending refresh is always taken from idle, so it clears there
      if (state_r == DP_IDLE && ref_pend_r)
         ref_pend_nxt = ref_tick && ref_cnt_r == 8'(REFRESH_TICKS - 1);
   end

   // ==========================================================
   // Port requests, sampled each clock (clock-high phase)
   // ==========================================================
   logic req_a, req_b, req_any;
   assign req_a   = !port_a_select_strobe_n_i;
   assign req_b   = !port_b_chip_select_n_i && !port_b_address_strobe_n_i;
   assign req_any = req_a || req_b;

   // ==========================================================
   // Sequencer
   // ==========================================================
   logic [3:0]         cnt_r, cnt_nxt;
   logic [CHAIN_LEN:1] dly_r, dly_nxt;
   logic               grant_b_r, grant_b_nxt;
   logic               is_ref_r, is_ref_nxt;
   logic               is_wr_r, is_wr_nxt;
   logic               is_burst_r, is_burst_nxt;
   logic               err_r, err_nxt;
   logic               ack_r, ack_nxt;
   logic               term_a_r, term_a_nxt;
   logic               term_b_r, term_b_nxt;
   logic               count_en;
   logic [3:0]         ack_at, row_end;
   dpedac_mem_t        mem_r, mem_nxt;
   dpedac_glue_t       glue_r, glue_nxt;

   // Chain advances only while an acked access or refresh runs
   assign count_en = (state_r == DP_ROW || state_r == DP_SCRUB) &&
                     (is_ref_r ? !mem_r.row_n[0] : ack_r);

   // Ack clock: one after strobe, plus one when wait-extend is low
   assign ack_at  = 4'(ACK_BASE_CLKS) +
                    (wait_extend_in_n_i ? 4'h0 : 4'(WAIT_EXTRA_CLKS));
   // Refresh length stretched by two on an error
   assign row_end = err_r ? 4'(SCRUB_ERR_CLKS - 1) : 4'(SCRUB_CLKS - 1);

   always_comb begin
      state_nxt    = state_r;
      cnt_nxt      = cnt_r;
      grant_b_nxt  = grant_b_r;
      is_ref_nxt   = is_ref_r;
      is_wr_nxt    = is_wr_r;
      is_burst_nxt = is_burst_r;
      err_nxt      = err_r;
      ack_nxt      = ack_r;
      term_a_nxt   = 1'b0;
      term_b_nxt   = 1'b0;
      mem_nxt      = mem_r;
      glue_nxt     = glue_r;
      // Delay chain: first stage set on first enable, later stages shift on enable
      dly_nxt      = dly_r;
      if (count_en) begin
         dly_nxt = {dly_r[CHAIN_LEN-1:1], 1'b1};
      end
      case (state_r)
         DP_IDLE: begin
            dly_nxt = '0;
            cnt_nxt = 4'h0;
            err_nxt = 1'b0;
            if (ref_pend_r || req_any) begin
               is_ref_nxt   = ref_pend_r;
               // Last owner keeps priority when both ports ask
               grant_b_nxt  = ref_pend_r ? grant_b_r :
                              (req_b && (!req_a || grant_b_r));
               is_wr_nxt    = !ref_pend_r &&
                              (grant_b_nxt ? port_b_write_i : port_a_write_i);
               is_burst_nxt = !ref_pend_r &&
                              (grant_b_nxt ? port_b_burst_i : port_a_burst_i);
               // Two strobes per group chosen by upper bank select
               mem_nxt.row_n        = ref_pend_r ? 4'h0 :
                                      (bank_select_i ? 4'h3 : 4'hC);
               // Zero column setup: switch row to column after hold
               mem_nxt.row_addr_sel = 1'b1;
               state_nxt            = ref_pend_r ? DP_SCRUB : DP_ROW;
            end
         end
         DP_ROW: begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == 4'(ROW_HOLD_CLKS - 1))
               mem_nxt.row_addr_sel = 1'b0;
            // Writes delay the column strobe one clock past reads
            if (cnt_r == 4'(is_wr_r ? WR_CAS_DELAY : 0))
               mem_nxt.col_n = 4'h0;
            // No burst waits: ack at the same clock for bursts
            if (cnt_r + 4'h1 == (is_burst_r ? 4'(ACK_BASE_CLKS + BURST_WAIT_CLKS)
                                            : ack_at))
               ack_nxt = 1'b1;
            // Read path opens once the acked chain runs; a four-clock
            // row never reaches the deep stages, so the enable is used
            if (!is_wr_r && count_en && !term_a_r && !term_b_r)
               glue_nxt.tran_en = 1'b1;
            if (!is_wr_r && count_en)
               glue_nxt.correction_data_output_enable = 1'b1;
            if (cnt_r == 4'(ROW_LOW_CLKS - 1)) begin
               mem_nxt.row_n = 4'hF;
               mem_nxt.col_n = 4'hF;
               ack_nxt       = 1'b0;
               // Termination only to the port that owns the access
               term_a_nxt    = !grant_b_r;
               term_b_nxt    = grant_b_r;
               cnt_nxt       = 4'h0;
               state_nxt     = DP_DONE;
            end
         end
         DP_SCRUB: begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == 4'(ROW_HOLD_CLKS - 1))
               mem_nxt.row_addr_sel = 1'b0;
            // Late-stage single error extends and enables write-back
            if (single_error_flag_i && dly_r[4]) begin
               err_nxt                              = 1'b1;
               glue_nxt.extend_refresh              = 1'b1;
               glue_nxt.correction_data_output_enable = 1'b1;
            end
            if (cnt_r == row_end) begin
               mem_nxt.row_n           = 4'hF;
               mem_nxt.col_n           = 4'hF;
               glue_nxt                = '0;
               cnt_nxt                 = 4'h0;
               state_nxt               = DP_PRECH;
            end
         end
         DP_DONE: begin
            // Transceiver drops once the termination has been given
            glue_nxt  = '0;
            state_nxt = DP_PRECH;
         end
         DP_PRECH: begin
            // Bank rests three clocks before the next strobe
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == 4'(ROW_PRECH_CLKS - 2)) begin
               cnt_nxt   = 4'h0;
               state_nxt = DP_IDLE;
            end
         end
         default: state_nxt = DP_IDLE;
      endcase
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r    <= DP_IDLE;
         cnt_r      <= 4'h0;
         dly_r      <= '0;
         grant_b_r  <= 1'b0;
         is_ref_r   <= 1'b0;
         is_wr_r    <= 1'b0;
         is_burst_r <= 1'b0;
         err_r      <= 1'b0;
         ack_r      <= 1'b0;
         term_a_r   <= 1'b0;
         term_b_r   <= 1'b0;
         mem_r      <= '{row_n: 4'hF, col_n: 4'hF, row_addr_sel: 1'b0};
         glue_r     <= '0;
         ref_cnt_r  <= 8'h00;
         ref_pend_r <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         cnt_r      <= cnt_nxt;
         dly_r      <= dly_nxt;
         grant_b_r  <= grant_b_nxt;
         is_ref_r   <= is_ref_nxt;
         is_wr_r    <= is_wr_nxt;
         is_burst_r <= is_burst_nxt;
         err_r      <= err_nxt;
         ack_r      <= ack_nxt;
         term_a_r   <= term_a_nxt;
         term_b_r   <= term_b_nxt;
         mem_r      <= mem_nxt;
         glue_r     <= glue_nxt;
         ref_cnt_r  <= ref_cnt_nxt;
         ref_pend_r <= ref_pend_nxt;
      end
   end

   // Outputs come straight from registers
   assign port_a_sync_termination_o = term_a_r;
   assign port_b_sync_termination_o = term_b_r;
   assign port_b_granted_o          = grant_b_r;
   assign access_ack_o              = ack_r;
   assign refresh_in_progress_o     = is_ref_r;
   assign mem_o                     = mem_r;
   assign glue_o                    = glue_r;
endmodule
`default_nettype wire

// [dv/dpedac_ctrl_checker.sv]
`default_nettype none
// ==========================================================
// Port-level checks of the controller
// ==========================================================
module dpedac_ctrl_checker
   import dpedac_pkg::*;
(
   // Clock and reset
   input wire logic         clk_i,
   input wire logic         rst_i,
   // Inputs watched
   input wire logic         port_a_write_i,
   input wire logic         port_a_burst_i,
   input wire logic         wait_extend_in_n_i,
   input wire logic         bank_select_i,
   // Outputs watched
   input wire logic         port_a_sync_termination_o,
   input wire logic         port_b_sync_termination_o,
   input wire logic         port_b_granted_o,
   input wire logic         access_ack_o,
   input wire logic         refresh_in_progress_o,
   input wire dpedac_mem_t  mem_o,
   input wire dpedac_glue_t glue_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [3:0] rn;
   logic       trm;
   // Shorthands
   assign rn = mem_o.row_n;
   assign trm = port_a_sync_termination_o | port_b_sync_termination_o;
   // An access drops one pair, a scrub drops all four at once
   a_row_four : assert property (
      trm |-> &rn && $past(rn) != 4'hF && $past(rn, 4) != 4'hF)
      else $error("row strobe not low four clocks");
   a_precharge_three : assert property (
      $rose(&rn) |-> (&rn)[*3]) else $error("precharge too short");
   a_ack_first : assert property (
      $fell(&rn) && rn != 4'h0 && wait_extend_in_n_i |=> access_ack_o)
      else $error("ack late");
   a_wait_extend : assert property (
      $fell(&rn) && rn != 4'h0 && !wait_extend_in_n_i && !$past(port_a_burst_i)
         |=> !access_ack_o ##1 access_ack_o)
      else $error("wait extend clock wrong");
   a_pair_select : assert property (
      $fell(&rn) && rn != 4'h0 |-> rn == ($past(bank_select_i) ? 4'h3 : 4'hC))
      else $error("wrong row pair");
   a_addr_mux : assert property (
      $fell(&rn) && rn != 4'h0 |-> mem_o.row_addr_sel ##1 !mem_o.row_addr_sel)
      else $error("address mux timing");
   a_write_cas : assert property (
      $fell(&rn) && rn != 4'h0 && $past(port_a_write_i)
         |=> &mem_o.col_n ##1 mem_o.col_n != 4'hF)
      else $error("write column strobe timing");
   a_scrub_len : assert property (
      $rose(rn == 4'h0) |-> (rn == 4'h0)[*6] ##1
         (rn == 4'hF or (rn == 4'h0)[*2] ##1 rn == 4'hF)) else $error("scrub length");
   a_extend_ref : assert property (
      glue_o.extend_refresh |-> refresh_in_progress_o) else $error("extend outside refresh");
   a_term_grant : assert property (
      trm |-> !(port_a_sync_termination_o && port_b_sync_termination_o)
         && port_b_sync_termination_o == port_b_granted_o) else $error("termination to wrong port");
   a_term_pulse : assert property (
      trm |=> !trm) else $error("termination wider than one clock");
endmodule
bind dpedac_ctrl dpedac_ctrl_checker u_chk (.clk_i, .rst_i, .port_a_write_i, .port_a_burst_i,
   .wait_extend_in_n_i, .bank_select_i, .port_a_sync_termination_o, .port_b_sync_termination_o,
   .port_b_granted_o, .access_ack_o, .refresh_in_progress_o, .mem_o, .glue_o);
`default_nettype wire

// [dv/dpedac_ecc_model.sv]
`default_nettype none
// ==========================================================
// Correction unit model: flags a single-bit error in scrubs
// ==========================================================
module dpedac_ecc_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Memory strobes and error request
   input  wire logic [3:0] row_n_i,
   input  wire logic       inject_i,
   // Error flag
   output logic            single_error_flag_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   // Count scrub cycles; the flag only settles late in the refresh
   always_comb begin
      cnt_nxt = (row_n_i == 4'h0 && cnt_r != 4'hF) ? cnt_r + 4'h1 : 4'h0;
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) cnt_r <= 4'h0;
      else cnt_r <= cnt_nxt;
   end
   assign single_error_flag_o = inject_i && row_n_i == 4'h0 && cnt_r >= 4'h3;
endmodule
`default_nettype wire

// [dv/test_dual_port_edac_dram_control.sv]
`default_nettype none
// ==========================================================
// Self-checking bench
// ==========================================================
module test_dual_port_edac_dram_control;
   import dpedac_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic         clk_i, rst_i, sa_n, csb_n, asb_n, wr, bu, wt_n, bk, inj, sef;
   logic         ta, tb, gr, ack, rip;
   dpedac_mem_t  mem_o;
   dpedac_glue_t glue_o;
   int           n_errors, checked;
   logic [31:0]  seed;
   dpedac_ctrl #(.REFRESH_TICKS(2)) dut (.clk_i, .rst_i, .port_a_select_strobe_n_i(sa_n),
      .port_a_write_i(wr), .port_a_burst_i(bu), .port_b_chip_select_n_i(csb_n),
      .port_b_address_strobe_n_i(asb_n), .port_b_write_i(wr), .port_b_burst_i(bu),
      .wait_extend_in_n_i(wt_n), .bank_select_i(bk), .single_error_flag_i(sef),
      .port_a_sync_termination_o(ta), .port_b_sync_termination_o(tb),
      .port_b_granted_o(gr), .access_ack_o(ack), .refresh_in_progress_o(rip), .mem_o, .glue_o);
   dpedac_ecc_model u_ecc (.clk_i, .rst_i, .row_n_i(mem_o.row_n), .inject_i(inj),
      .single_error_flag_o(sef));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Bursts skip the extra wait; a low wait input adds one clock
   function automatic int ack_exp(input bit x, input bit u);
      return (x || u) ? 1 : 2;
   endfunction
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task automatic tally_and_finish;
      if (n_errors == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // One access; the request is held until its termination
   task automatic acc(input bit b, input bit w, input bit u, input bit x, input bit y);
      int k, ak;
      logic te, oe;
      ak = -1;
      te = 1'b0;
      oe = 1'b0;
      k = 0;
      @(posedge clk_i);
      wr <= w;
      bu <= u;
      wt_n <= x;
      bk <= y;
      if (b) begin
         csb_n <= 1'b0;
         asb_n <= 1'b0;
      end else sa_n <= 1'b0;
      do begin
         @(negedge clk_i);
         k++;
      end while (mem_o.row_n !== (y ? 4'h3 : 4'hC) && k < 200);
      chk("start", k < 200, 1'b1);
      k = 0;
      while (ta !== 1'b1 && tb !== 1'b1 && k < 20) begin
         if (ack === 1'b1 && ak < 0) ak = k;
         te |= glue_o.tran_en;
         oe |= glue_o.correction_data_output_enable;
         k++;
         @(negedge clk_i);
      end
      chk("row_low", 8'(k), 8'h04);
      chk("ack", 8'(ak), 8'(ack_exp(x, u)));
      chk("term_a", ta, !b);
      chk("term_b", tb, b);
      chk("grant", gr, b);
      chk("rip_acc", rip, 1'b0);
      chk("tran", te, !w);
      chk("oe", oe, !w);
      @(posedge clk_i);
      sa_n <= 1'b1;
      csb_n <= 1'b1;
      asb_n <= 1'b1;
   endtask
   // One scrubbing refresh, with or without a flagged error
   task automatic scrub(input bit e);
      int k;
      logic ex, oe, rp;
      k = 0;
      ex = 1'b0;
      oe = 1'b0;
      @(posedge clk_i);
      inj <= e;
      do begin
         @(negedge clk_i);
         k++;
      end while (mem_o.row_n !== 4'h0 && k < 200);
      rp = rip;
      k = 0;
      while (mem_o.row_n === 4'h0 && k < 20) begin
         ex |= glue_o.extend_refresh;
         oe |= glue_o.correction_data_output_enable;
         k++;
         @(negedge clk_i);
      end
      chk("scrub_len", 8'(k), e ? 8'h08 : 8'h06);
      chk("extend", ex, e);
      chk("scrub_oe", oe, e);
      chk("rip", rp, 1'b1);
   endtask
   // Clock of 50 ns; at 20 MHz no external halving is needed
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // Watchdog, far beyond the expected run
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      tally_and_finish;
   end
   // Main sequence: reset, scrubs, corner accesses, random accesses
   initial begin
      {sa_n, csb_n, asb_n, wt_n} = 4'hF;
      {wr, bu, bk, inj} = 4'h0;
      n_errors = 0;
      checked = 0;
      seed = 32'hEA0CC7BB;
      rst_i = 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk("reset_row", mem_o.row_n, 4'hF);
      chk("reset_ack", ack, 1'b0);
      scrub(1'b0);
      scrub(1'b1);
      for (int i = 0; i < 8; i++) acc(i[0], i[1], 1'b0, i[2], i[0] ^ i[1]);
      acc(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
      repeat (16) begin
         seed = lfsr(seed);
         acc(seed[0], seed[1], seed[2], seed[3], seed[4]);
      end
      scrub(1'b1);
      tally_and_finish;
   end
endmodule
`default_nettype wire
